// ===== include/alc_level_if.sv
`timescale 1ns/1ps
interface alc_level_if;
    import codec_tieoff_pkg::*;
    logic [LEVEL_W-1:0] left_pk2pk; // raw left peak-to-peak
    logic [LEVEL_W-1:0] right_pk2pk; // raw right peak-to-peak
    logic [LEVEL_W-1:0] left_peak; // raw left peak
    logic [LEVEL_W-1:0] right_peak; // raw right peak
    logic left_alc_en; // left under level control
    logic right_alc_en; // right under level control
    logic noise_gate_source_select; // 0 peak, 1 peak-to-peak
    logic [LEVEL_W-1:0] gate_threshold; // noise gate threshold
    logic [LEVEL_W-1:0] alc_pk2pk_level; // combined readout
    logic [LEVEL_W-1:0] alc_peak_level; // combined readout
    logic noise_gate_active_flag; // signal below threshold

    modport core (
        output left_pk2pk, right_pk2pk, left_peak, right_peak,
        output left_alc_en, right_alc_en,
        output noise_gate_source_select, gate_threshold,
        input alc_pk2pk_level, alc_peak_level, noise_gate_active_flag
    );
    modport monitor (
        input left_pk2pk, right_pk2pk, left_peak, right_peak,
        input left_alc_en, right_alc_en,
        input noise_gate_source_select, gate_threshold,
        output alc_pk2pk_level, alc_peak_level, noise_gate_active_flag
    );
endinterface : alc_level_if

// ===== include/codec_tieoff_pkg.sv
package codec_tieoff_pkg;

    // register port geometry
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;
    localparam int LEVEL_W = 9;
    localparam int SAMPLE_W = 24;
    localparam int TIEOFF_N = 8;
    localparam int VREF_N = 3;

    // register addresses
    localparam logic [6:0] ADDR_INPUT_TIEOFF = 7'h4A;
    localparam logic [6:0] ADDR_BIAS_TIEOFF = 7'h4B;
    localparam logic [6:0] ADDR_PK2PK = 7'h4C;
    localparam logic [6:0] ADDR_PEAK = 7'h4D;
    localparam logic [6:0] ADDR_AUTOMUTE = 7'h4E;

    // reset values
    localparam logic [8:0] INPUT_TIEOFF_RST = 9'h000;
    localparam logic [8:0] BIAS_TIEOFF_RST = 9'h000;
    localparam logic [8:0] ZERO_WORD = 9'h000;

    // input tie-off register: [8] override, [7:0] per-input force
    // [7] r aux, [6] r line, [5] r mic-, [4] r mic+,
    // [3] l aux, [2] l line, [1] l mic-, [0] l mic+
    localparam int OVR_EN_BIT = 8;

    // bias and tie-off register fields, bit 7 reserved
    localparam int BIAS_HALF_BIT = 8;
    localparam int BIAS_INC_BIT = 6;
    localparam int BIAS_DEC_BIT = 5;
    localparam int BUF_BYPASS_BIT = 4;
    localparam int BUF_GROUND_BIT = 3;
    localparam int VREF_LSB = 0;
    localparam logic [8:0] BIAS_WR_MASK = 9'h17F;

    // automute control and status register fields
    localparam int AMUTE_SEL_BIT = 5;
    localparam int HV_FLAG_BIT = 4;
    localparam int NGATE_BIT = 3;
    localparam logic AMUTE_SEL_RST = 1'h0;

endpackage : codec_tieoff_pkg

// ===== rtl/alc_level_monitor.sv
`timescale 1ns/1ps
module alc_level_monitor
    import codec_tieoff_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    alc_level_if.monitor lvl
);

    // all state of the monitor
    typedef struct packed {
        logic [LEVEL_W-1:0] pk2pk;
        logic [LEVEL_W-1:0] peak;
        logic gate;
    } mon_state_t;

    mon_state_t st_r;
    mon_state_t st_nxt;

    // pick the channel value; larger one when both are controlled
    function automatic logic [LEVEL_W-1:0] pick_level(
        input logic [LEVEL_W-1:0] lv,
        input logic [LEVEL_W-1:0] rv,
        input logic len,
        input logic ren
    );
        if (len && ren) begin
            pick_level = (lv > rv) ? lv : rv;
        end else if (ren) begin
            pick_level = rv;
        end else begin
            pick_level = lv;
        end
    endfunction : pick_level

    // combine channels and evaluate the noise gate
    always_comb begin
        st_nxt = st_r;
        st_nxt.pk2pk = pick_level(lvl.left_pk2pk, lvl.right_pk2pk,
            lvl.left_alc_en, lvl.right_alc_en);
        st_nxt.peak = pick_level(lvl.left_peak, lvl.right_peak,
            lvl.left_alc_en, lvl.right_alc_en);
        // gate compares the freshly combined level of the chosen detector
        if (lvl.noise_gate_source_select) begin
            st_nxt.gate = st_nxt.pk2pk < lvl.gate_threshold;
        end else begin
            st_nxt.gate = st_nxt.peak < lvl.gate_threshold;
        end
    end

    // register the whole state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lvl.alc_pk2pk_level = st_r.pk2pk;
    assign lvl.alc_peak_level = st_r.peak;
    assign lvl.noise_gate_active_flag = st_r.gate;

endmodule : alc_level_monitor

// ===== rtl/tieoff_override_and_alc_readout_regs.sv
`timescale 1ns/1ps

module tieoff_override_and_alc_readout_regs
    import codec_tieoff_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    // register port from the serial control interface
    input wire logic reg_wr_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wr_data,
    output logic [DATA_W-1:0] reg_rd_data,
    // automatic switch requests from the analog sequencer
    input wire logic [TIEOFF_N-1:0] auto_tieoff_sw,
    input wire logic input_buffer_disabled,
    input wire logic auto_buffer_bypass,
    input wire logic auto_buffer_ground,
    input wire logic [VREF_N-1:0] vref_pm_sw,
    // level detector values per channel
    input wire logic [LEVEL_W-1:0] left_pk2pk_in,
    input wire logic [LEVEL_W-1:0] right_pk2pk_in,
    input wire logic [LEVEL_W-1:0] left_peak_in,
    input wire logic [LEVEL_W-1:0] right_peak_in,
    input wire logic left_alc_active,
    input wire logic right_alc_active,
    input wire logic noise_gate_source_select,
    input wire logic [LEVEL_W-1:0] noise_gate_threshold,
    // speaker supply detector
    input wire logic speaker_supply_high_det,
    // candidate automute observation data
    input wire logic [SAMPLE_W-1:0] attenuator_in_sample,
    input wire logic [SAMPLE_W-1:0] serial_dac_input_sample,
    // analog switch controls
    output logic [TIEOFF_N-1:0] tieoff_sw_close,
    output logic input_tieoff_override_flag,
    output logic buffer_bypass_close,
    output logic buffer_ground_close,
    output logic [VREF_N-1:0] vref_ground_close,
    // mix/boost bias controls
    output logic mixboost_bias_half,
    output logic mixboost_bias_increase,
    output logic mixboost_bias_decrease,
    // automute and level control hooks
    output logic automute_point_select,
    output logic [SAMPLE_W-1:0] automute_obs_sample,
    output logic alc_gain_hold,
    output logic speaker_supply_high_flag
);

    // all state of the register bank
    typedef struct packed {
        logic [DATA_W-1:0] input_tieoff; // input tie-off register
        logic [DATA_W-1:0] bias_tieoff; // bias and tie-off register
        logic amute_sel; // automute observation select
        logic hv_flag; // sampled detector output
        logic [DATA_W-1:0] rd_data; // read answer
        logic [TIEOFF_N-1:0] tieoff_sw; // switch drive
        logic buf_bypass; // bypass switch drive
        logic buf_ground; // ground switch drive
        logic [VREF_N-1:0] vref_sw; // vref ground switches
        logic bias_half; // half bias drive
        logic bias_inc; // bias increase drive
        logic bias_dec; // bias decrease drive
        logic [SAMPLE_W-1:0] amute_data; // observed sample
    } bank_state_t;

    bank_state_t st_r; // registered state
    bank_state_t st_nxt; // next state

    alc_level_if lvl (); // carrier to the level monitor

    // write decode for one address
    function automatic logic wr_hit(
        input logic en,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        wr_hit = en && (addr == target);
    endfunction : wr_hit

    // manual force with buffer-off qualification
    function automatic logic buf_switch(
        input logic force_bit,
        input logic buf_off,
        input logic auto_req
    );
        // forcing only matters while the buffer is off;
        // when it runs the sequencer still owns the switch
        if (force_bit && buf_off) begin
            buf_switch = 1'h1;
        end else begin
            buf_switch = auto_req;
        end
    endfunction : buf_switch

    // read view of the automute control and status register
    function automatic logic [DATA_W-1:0] amute_word(
        input logic sel,
        input logic hv,
        input logic gate
    );
        amute_word = ZERO_WORD; // reserved bits read zero
        amute_word[AMUTE_SEL_BIT] = sel;
        amute_word[HV_FLAG_BIT] = hv;
        amute_word[NGATE_BIT] = gate;
    endfunction : amute_word

    // feed raw detector values into the monitor
    assign lvl.left_pk2pk = left_pk2pk_in;
    assign lvl.right_pk2pk = right_pk2pk_in;
    assign lvl.left_peak = left_peak_in;
    assign lvl.right_peak = right_peak_in;
    assign lvl.left_alc_en = left_alc_active;
    assign lvl.right_alc_en = right_alc_active;
    assign lvl.noise_gate_source_select = noise_gate_source_select;
    assign lvl.gate_threshold = noise_gate_threshold;

    // level combining and noise gate
    alc_level_monitor u_level_monitor (
        .mclk (mclk),
        .reset (reset),
        .lvl (lvl.monitor)
    );

    // next-state logic of the whole bank
    always_comb begin
        st_nxt = st_r;

        // register writes; read-only addresses fall through
        if (wr_hit(reg_wr_en, reg_addr, ADDR_INPUT_TIEOFF)) begin
            st_nxt.input_tieoff = reg_wr_data;
        end
        if (wr_hit(reg_wr_en, reg_addr, ADDR_BIAS_TIEOFF)) begin
            // reserved bit never stores, so it reads back zero
            st_nxt.bias_tieoff = reg_wr_data & BIAS_WR_MASK;
        end
        if (wr_hit(reg_wr_en, reg_addr, ADDR_AUTOMUTE)) begin
            // only the select bit is writable; status bits are
            // rebuilt from live state on every read
            st_nxt.amute_sel = reg_wr_data[AMUTE_SEL_BIT];
        end

        // detector is synchronous to mclk, one stage is enough
        st_nxt.hv_flag = speaker_supply_high_det;

        // tie-off switches: manual pattern or sequencer
        if (st_r.input_tieoff[OVR_EN_BIT]) begin
            // right half of the force field
            st_nxt.tieoff_sw[7:4] = st_r.input_tieoff[7:4];
            // left half of the force field
            st_nxt.tieoff_sw[3:0] = st_r.input_tieoff[3:0];
        end else begin
            st_nxt.tieoff_sw = auto_tieoff_sw;
        end

        // buffer bypass and ground switches
        st_nxt.buf_bypass = buf_switch(
            st_r.bias_tieoff[BUF_BYPASS_BIT],
            input_buffer_disabled, auto_buffer_bypass);
        st_nxt.buf_ground = buf_switch(
            st_r.bias_tieoff[BUF_GROUND_BIT],
            input_buffer_disabled, auto_buffer_ground);

        // vref ground switches: force closed or power setting
        st_nxt.vref_sw = st_r.bias_tieoff[VREF_LSB +: VREF_N]
            | vref_pm_sw;

        // bias controls go straight to the analog trim
        st_nxt.bias_half = st_r.bias_tieoff[BIAS_HALF_BIT];
        st_nxt.bias_inc = st_r.bias_tieoff[BIAS_INC_BIT];
        st_nxt.bias_dec = st_r.bias_tieoff[BIAS_DEC_BIT];

        // automute observation point
        if (st_r.amute_sel) begin
            st_nxt.amute_data = serial_dac_input_sample;
        end else begin
            st_nxt.amute_data = attenuator_in_sample;
        end

        // read answer, valid the cycle after the address
        case (reg_addr)
            ADDR_INPUT_TIEOFF: begin
                st_nxt.rd_data = st_r.input_tieoff;
            end
            ADDR_BIAS_TIEOFF: begin
                st_nxt.rd_data = st_r.bias_tieoff;
            end
            ADDR_PK2PK: begin
                st_nxt.rd_data = lvl.alc_pk2pk_level;
            end
            ADDR_PEAK: begin
                st_nxt.rd_data = lvl.alc_peak_level;
            end
            ADDR_AUTOMUTE: begin
                st_nxt.rd_data = amute_word(st_r.amute_sel,
                    st_r.hv_flag, lvl.noise_gate_active_flag);
            end
            default: begin
                // unmapped addresses answer zero
                st_nxt.rd_data = ZERO_WORD;
            end
        endcase
    end

    // register the whole state; control starts at defaults
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.input_tieoff <= INPUT_TIEOFF_RST;
            st_r.bias_tieoff <= BIAS_TIEOFF_RST;
            st_r.amute_sel <= AMUTE_SEL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs come from the registered state; alc_gain_hold comes from the level monitor's register
    assign reg_rd_data = st_r.rd_data;
    assign tieoff_sw_close = st_r.tieoff_sw;
    assign input_tieoff_override_flag = st_r.input_tieoff[OVR_EN_BIT];
    assign buffer_bypass_close = st_r.buf_bypass;
    assign buffer_ground_close = st_r.buf_ground;
    assign vref_ground_close = st_r.vref_sw;
    assign mixboost_bias_half = st_r.bias_half;
    assign mixboost_bias_increase = st_r.bias_inc;
    assign mixboost_bias_decrease = st_r.bias_dec;
    assign automute_point_select = st_r.amute_sel;
    assign automute_obs_sample = st_r.amute_data;
    // gain freezes while the gate reports a quiet input
    assign alc_gain_hold = lvl.noise_gate_active_flag;
    assign speaker_supply_high_flag = st_r.hv_flag;

endmodule : tieoff_override_and_alc_readout_regs

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import codec_tieoff_pkg::*;
;
    logic mclk, reset, reg_wr_en;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wr_data, reg_rd_data, rd_v;
    logic [TIEOFF_N-1:0] auto_tieoff_sw, tieoff_sw_close;
    logic input_buffer_disabled, auto_buffer_bypass, auto_buffer_ground;
    logic [VREF_N-1:0] vref_pm_sw, vref_ground_close;
    logic [LEVEL_W-1:0] left_pk2pk_in, right_pk2pk_in, left_peak_in;
    logic [LEVEL_W-1:0] right_peak_in, noise_gate_threshold;
    logic left_alc_active, right_alc_active, noise_gate_source_select;
    logic speaker_supply_high_det, input_tieoff_override_flag;
    logic [SAMPLE_W-1:0] attenuator_in_sample, serial_dac_input_sample;
    logic [SAMPLE_W-1:0] automute_obs_sample;
    logic buffer_bypass_close, buffer_ground_close, automute_point_select;
    logic mixboost_bias_half, mixboost_bias_increase, mixboost_bias_decrease;
    logic alc_gain_hold, speaker_supply_high_flag;
    int n_errors = 0; // mismatches seen
    int num_checks = 0; // comparisons made
    // one write and the readback it should give
    typedef struct packed {logic [6:0] a; logic [8:0] d; logic [8:0] e;} row_t;
    row_t rows [9] = '{'{7'h4A, 9'h1FF, 9'h1FF}, '{7'h4A, 9'h0A5, 9'h0A5},
        '{7'h4B, 9'h1FF, 9'h17F}, '{7'h4B, 9'h080, 9'h000},
        '{7'h4E, 9'h1FF, 9'h020}, '{7'h4E, 9'h000, 9'h000},
        '{7'h4C, 9'h1FF, 9'h000}, '{7'h4D, 9'h1FF, 9'h000},
        '{7'h50, 9'h1FF, 9'h000}};

    tieoff_override_and_alc_readout_regs i_dut (.*);

    // free-running master clock, 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // one-cycle write strobe, launched at the falling edge
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge mclk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge mclk);
        reg_wr_en = 1'b0;
    endtask : wr

    // readback is registered, so it lands one cycle after the address
    task automatic rd(input logic [6:0] a);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        rd_v = reg_rd_data;
    endtask : rd

    // covers the two-stage path from detector input to readback
    task automatic settle;
        repeat (3) @(negedge mclk);
    endtask : settle

    task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_out

    task automatic chk_reg(input logic [8:0] got, input logic [8:0] exp);
        chk_out({15'h0000, got}, {15'h0000, exp});
    endtask : chk_reg

    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // a hang stops well past the 140 or so cycles the tests need
    initial begin
        #(100 * 3000);
        n_errors++;
        end_of_test();
    end

    initial begin
        {reg_wr_en, reg_addr, reg_wr_data, auto_tieoff_sw, vref_pm_sw,
            input_buffer_disabled, auto_buffer_bypass, auto_buffer_ground,
            left_pk2pk_in, right_pk2pk_in, left_peak_in, right_peak_in,
            left_alc_active, right_alc_active, noise_gate_source_select,
            noise_gate_threshold, speaker_supply_high_det,
            attenuator_in_sample, serial_dac_input_sample} = '0;
        reset = 1'b1;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        rd(ADDR_INPUT_TIEOFF);
        chk_reg(rd_v, INPUT_TIEOFF_RST);
        rd(ADDR_BIAS_TIEOFF);
        chk_reg(rd_v, BIAS_TIEOFF_RST);
        rd(ADDR_AUTOMUTE);
        chk_reg(rd_v, ZERO_WORD);
        $display("test reset values done");
        // register table: stored bits, reserved bits, read-only places
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk_reg(rd_v, rows[i].e);
        end
        $display("test register rows done");
        // override off, then right-only and left-only force patterns
        auto_tieoff_sw = 8'h5A;
        settle();
        chk_out(tieoff_sw_close, 8'h5A);
        wr(ADDR_INPUT_TIEOFF, 9'h1F0);
        settle();
        chk_out(tieoff_sw_close, 8'hF0);
        chk_out(input_tieoff_override_flag, 1'h1);
        wr(ADDR_INPUT_TIEOFF, 9'h10F);
        settle();
        chk_out(tieoff_sw_close, 8'h0F);
        wr(ADDR_INPUT_TIEOFF, 9'h0FF);
        settle();
        chk_out(tieoff_sw_close, 8'h5A);
        $display("test tie-off override done");
        // each bias control alone: half, increase, decrease
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_BIAS_TIEOFF, (i == 0) ? 9'h100 : (i == 1) ? 9'h040 : 9'h020);
            settle();
            chk_out({mixboost_bias_half, mixboost_bias_increase,
                mixboost_bias_decrease}, 3'h4 >> i);
        end
        // buffer forces act only while the buffer is off; vref forces act with the buffer on
        input_buffer_disabled = 1'b1;
        wr(ADDR_BIAS_TIEOFF, 9'h018);
        settle();
        chk_out({buffer_bypass_close, buffer_ground_close}, 2'h3);
        input_buffer_disabled = 1'b0;
        auto_buffer_ground = 1'b1;
        settle();
        chk_out({buffer_bypass_close, buffer_ground_close}, 2'h1);
        auto_buffer_ground = 1'b0;
        vref_pm_sw = 3'h2;
        wr(ADDR_BIAS_TIEOFF, 9'h005);
        settle();
        chk_out(vref_ground_close, 3'h7);
        wr(ADDR_BIAS_TIEOFF, 9'h000);
        settle();
        chk_out(vref_ground_close, 3'h2);
        $display("test bias and switches done");
        // level readouts with both channels active, then only the right one
        left_pk2pk_in = 9'h010;
        right_pk2pk_in = 9'h020;
        left_peak_in = 9'h130;
        right_peak_in = 9'h008;
        {left_alc_active, right_alc_active} = 2'h3;
        settle();
        rd(ADDR_PK2PK);
        chk_reg(rd_v, 9'h020);
        rd(ADDR_PEAK);
        chk_reg(rd_v, 9'h130);
        {left_alc_active, right_alc_active} = 2'h1;
        settle();
        rd(ADDR_PK2PK);
        chk_reg(rd_v, 9'h020);
        rd(ADDR_PEAK);
        chk_reg(rd_v, 9'h008);
        // gate on peak 0x008 then on pk2pk 0x020, equal is not below
        noise_gate_threshold = 9'h010;
        settle();
        chk_out(alc_gain_hold, 1'h1);
        rd(ADDR_AUTOMUTE);
        chk_reg(rd_v, 9'h008);
        noise_gate_source_select = 1'b1;
        noise_gate_threshold = 9'h020;
        settle();
        chk_out(alc_gain_hold, 1'h0);
        noise_gate_threshold = 9'h000;
        $display("test level readouts done");
        // automute source switch and read-only status bits
        attenuator_in_sample = 24'hAAAAAA;
        serial_dac_input_sample = 24'h555555;
        settle();
        chk_out(automute_obs_sample, 24'hAAAAAA);
        wr(ADDR_AUTOMUTE, 9'h020);
        speaker_supply_high_det = 1'b1;
        settle();
        chk_out(automute_obs_sample, 24'h555555);
        chk_out(automute_point_select, 1'h1);
        chk_out(speaker_supply_high_flag, 1'h1);
        wr(ADDR_AUTOMUTE, 9'h1DF);
        rd(ADDR_AUTOMUTE);
        chk_reg(rd_v, 9'h010);
        $display("test automute and status done");
        // reset in mid-run clears stored control bits
        wr(ADDR_INPUT_TIEOFF, 9'h1FF);
        reset = 1'b1;
        @(negedge mclk);
        chk_out(tieoff_sw_close, 8'h00);
        reset = 1'b0;
        rd(ADDR_INPUT_TIEOFF);
        chk_reg(rd_v, INPUT_TIEOFF_RST);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : tb_top

// ===== verif/tieoff_regs_properties.sv
`timescale 1ns/1ps
module tieoff_regs_properties
    import codec_tieoff_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic reg_wr_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wr_data,
    input wire logic [DATA_W-1:0] reg_rd_data,
    input wire logic [TIEOFF_N-1:0] auto_tieoff_sw,
    input wire logic input_buffer_disabled,
    input wire logic auto_buffer_bypass,
    input wire logic auto_buffer_ground,
    input wire logic [VREF_N-1:0] vref_pm_sw,
    input wire logic [LEVEL_W-1:0] left_pk2pk_in,
    input wire logic [LEVEL_W-1:0] right_pk2pk_in,
    input wire logic [LEVEL_W-1:0] left_peak_in,
    input wire logic [LEVEL_W-1:0] right_peak_in,
    input wire logic left_alc_active,
    input wire logic right_alc_active,
    input wire logic noise_gate_source_select,
    input wire logic [LEVEL_W-1:0] noise_gate_threshold,
    input wire logic speaker_supply_high_det,
    input wire logic [SAMPLE_W-1:0] attenuator_in_sample,
    input wire logic [SAMPLE_W-1:0] serial_dac_input_sample,
    input wire logic [TIEOFF_N-1:0] tieoff_sw_close,
    input wire logic input_tieoff_override_flag,
    input wire logic buffer_bypass_close,
    input wire logic buffer_ground_close,
    input wire logic [VREF_N-1:0] vref_ground_close,
    input wire logic mixboost_bias_half,
    input wire logic mixboost_bias_increase,
    input wire logic mixboost_bias_decrease,
    input wire logic automute_point_select,
    input wire logic [SAMPLE_W-1:0] automute_obs_sample,
    input wire logic alc_gain_hold,
    input wire logic speaker_supply_high_flag
);
    // larger channel when both active, else the active one, else left
    function automatic logic [8:0] pick(input logic [8:0] lv, rv,
        input logic le, re);
        if (le && re) begin
            return (lv > rv) ? lv : rv;
        end
        return (re && !le) ? rv : lv;
    endfunction : pick

    logic [8:0] pk2pk_exp; // expected combined peak-to-peak
    logic [8:0] peak_exp; // expected combined peak
    logic gate_exp; // equal level counts as above the threshold
    logic [2:0] bias_bits; // half, increase, decrease write fields
    assign pk2pk_exp = pick(left_pk2pk_in, right_pk2pk_in,
        left_alc_active, right_alc_active);
    assign peak_exp = pick(left_peak_in, right_peak_in,
        left_alc_active, right_alc_active);
    assign gate_exp = (noise_gate_source_select ? pk2pk_exp : peak_exp)
        < noise_gate_threshold;
    assign bias_bits = {reg_wr_data[8], reg_wr_data[6:5]};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // switches lag the stored override bit by one cycle
    tieoff_auto_a: assert property (!$past(reset) &&
        !$past(input_tieoff_override_flag) |->
        tieoff_sw_close == $past(auto_tieoff_sw))
        else $error("tie-off switches do not follow automatic requests");
    bias_ctrl_a: assert property (reg_wr_en &&
        reg_addr == ADDR_BIAS_TIEOFF |=> ##1 {mixboost_bias_half,
        mixboost_bias_increase, mixboost_bias_decrease} == $past(bias_bits, 2))
        else $error("bias controls do not follow the written bits");
    buffer_auto_a: assert property (!$past(reset) &&
        !$past(input_buffer_disabled) |-> {buffer_bypass_close,
        buffer_ground_close} == {$past(auto_buffer_bypass),
        $past(auto_buffer_ground)})
        else $error("buffer switches forced while buffer enabled");
    vref_keep_a: assert property (!$past(reset) |->
        (vref_ground_close & $past(vref_pm_sw)) == $past(vref_pm_sw))
        else $error("vref switch opened against power setting");
    pk2pk_read_a: assert property ($past(reg_addr) == ADDR_PK2PK &&
        $past(reg_addr, 2) == ADDR_PK2PK && !$past(reset) && !$past(reset, 2)
        |-> reg_rd_data == $past(pk2pk_exp, 2))
        else $error("peak-to-peak readout wrong");
    peak_read_a: assert property ($past(reg_addr) == ADDR_PEAK &&
        $past(reg_addr, 2) == ADDR_PEAK && !$past(reset) && !$past(reset, 2)
        |-> reg_rd_data == $past(peak_exp, 2))
        else $error("peak readout wrong");
    mute_sel_a: assert property (!$past(reset) |->
        automute_obs_sample == ($past(automute_point_select) ?
        $past(serial_dac_input_sample) : $past(attenuator_in_sample)))
        else $error("automute observation source wrong");
    hv_flag_a: assert property (!$past(reset) |->
        speaker_supply_high_flag == $past(speaker_supply_high_det))
        else $error("high voltage flag does not track detector");
    gate_hold_a: assert property (!$past(reset) |->
        alc_gain_hold == $past(gate_exp))
        else $error("noise gate hold wrong");
endmodule : tieoff_regs_properties

bind tieoff_override_and_alc_readout_regs tieoff_regs_properties i_props (.*);
